// >>> hdl/tbi_pkg.sv
// Types shared by the two-wire bus block
package tbi_pkg;

    // Clock generator states, Gray coded along idle, start, low, high
    typedef enum logic [2:0] {
        TBI_IDLE  = 3'h0,
        TBI_START = 3'h1,
        TBI_LOW   = 3'h3,
        TBI_HIGH  = 3'h2
    } tbi_state_t;

    // Bus status register layout
    typedef struct packed {
        logic master_select;
        logic trx;
        logic bb;
        logic pin;
        logic al;
        logic aas;
        logic ad0;
        logic last_received_bit;
    } tbi_sr_t;

    // Control register one layout
    typedef struct packed {
        logic [2:0] bcs;
        logic       ack;
        logic       done;
        logic [2:0] rate;
    } tbi_cr1_t;

endpackage

// >>> hdl/tbi_regs.svh
// Register offsets, field positions, reset values and timing counts of the two-wire bus block
`ifndef TBI_REGS_SVH
`define TBI_REGS_SVH

// Register byte offsets
`define TBI_CR1_OFS    8'h00
`define TBI_CR2_OFS    8'h04
`define TBI_SR_OFS     8'h08
`define TBI_DBUF_OFS   8'h0c
`define TBI_OAR_OFS    8'h10
`define TBI_IDLE_OFS   8'h14

// Control register two fields
`define TBI_CR2_MST    7
`define TBI_CR2_TRX    6
`define TBI_CR2_BB     5
`define TBI_CR2_PIN    4
`define TBI_CR2_MODE_HI 3
`define TBI_CR2_MODE_LO 2
`define TBI_CR2_SWR_HI 1
`define TBI_CR2_SWR_LO 0

// Codes
`define TBI_MODE_I2C   2'h2
`define TBI_MODE_PORT  2'h0
`define TBI_SWR_FIRST  2'h2
`define TBI_SWR_SECOND 2'h1
`define TBI_GEN_CALL   8'h00

// Reset values
`define TBI_CR1_RST    8'h08
`define TBI_OAR_RST    8'h00

// Clock period formula: low = 2^(n-1)+29, high = 2^(n-1)+7 prescaled cycles, n = rate+4
`define TBI_LOW_BASE   29
`define TBI_HIGH_BASE  7
`define TBI_N_LOG_OFS  3
`define TBI_PRESCALE   2
`define TBI_RATE_MAX   3'h6
`define TBI_WORD_BITS  4'h8
`define TBI_WORD_ACK   4'h9

`endif

// >>> hdl/tbi_top.sv
// Two-wire bus interface with bus monitor, start generation and AHB-Lite registers
`timescale 1ns/100ps
`include "tbi_regs.svh"

module tbi_top (
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // System state
    input  wire logic        low_power_idle_mode,
    output logic             transfer_interrupt,
    // Open-drain bus pins
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    tbi_pkg::tbi_sr_t    st;
    tbi_pkg::tbi_cr1_t   cr1;
    tbi_pkg::tbi_state_t state;
    logic [1:0]  mode;
    logic [7:0]  oar;
    logic        low_power_idle_mode_run_select;
    logic        swr_armed;
    logic        srst;
    logic        scl_s1, scl_s2, scl_d;
    logic        sda_s1, sda_s2, sda_d;
    logic [7:0]  shreg;
    logic [3:0]  bitn;
    logic        first_word;
    logic        start_hold;
    logic        slv_hold;
    logic [11:0] cnt;
    logic        ap_wr;
    logic [7:0]  ap_addr;
    logic        run, i2c_en;
    logic        scl_rise, scl_fall, start_det, stop_det;
    logic        addr_valid, rd_now, wr_now, dbuf_acc, cr2_wr;
    logic        go, word_end, irq_evt, drive_data, ack_low, al_evt;
    logic [3:0]  last_bit;
    logic [7:0]  rx_byte;
    logic [7:0]  rd_val;
    logic [11:0] t_low, t_high;

    // Period counts from the rate field, unused code 7 treated as 6
    function automatic logic [11:0] half_cnt(input logic [2:0] r, input int base);
        logic [2:0] rr;
        rr = (r > `TBI_RATE_MAX) ? `TBI_RATE_MAX : r;
        half_cnt = 12'(`TBI_PRESCALE * ((1 << (rr + `TBI_N_LOG_OFS)) + base));
    endfunction

    assign t_low  = half_cnt(cr1.rate, `TBI_LOW_BASE);
    assign t_high = half_cnt(cr1.rate, `TBI_HIGH_BASE);

    // Engine stops in idle mode unless told to keep running
    assign run    = ce && !(low_power_idle_mode && !low_power_idle_mode_run_select);
    assign i2c_en = (mode == `TBI_MODE_I2C);

    // ----------------------------------------
    // Pin synchronisers and bus event detection
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_d  <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_d  <= 1'b1;
        end else if (run) begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_d  <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_d  <= sda_s2;
        end
    end

    // Edge and condition strobes, only in bus mode and while running
    assign scl_rise  = run && i2c_en && scl_s2 && !scl_d;
    assign scl_fall  = run && i2c_en && !scl_s2 && scl_d;
    assign start_det = run && i2c_en && scl_s2 && scl_d && sda_d && !sda_s2;
    assign stop_det  = run && i2c_en && scl_s2 && scl_d && !sda_d && sda_s2;

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    assign hreadyout  = ce;
    assign hresp      = 1'b0;
    assign addr_valid = hsel && htrans[1] && hready && ce;
    assign rd_now     = addr_valid && !hwrite;
    assign wr_now     = ap_wr && ce;
    assign cr2_wr     = wr_now && (ap_addr == `TBI_CR2_OFS);
    assign dbuf_acc   = (rd_now && (haddr == `TBI_DBUF_OFS)) ||
                        (wr_now && (ap_addr == `TBI_DBUF_OFS));
    assign rx_byte    = shreg;

    // Read value mux
    always_comb begin
        unique case (haddr)
            `TBI_CR1_OFS:  rd_val = cr1;
            `TBI_CR2_OFS:  rd_val = st;
            `TBI_SR_OFS:   rd_val = st;
            `TBI_DBUF_OFS: rd_val = rx_byte;
            `TBI_IDLE_OFS: rd_val = {7'h00, low_power_idle_mode_run_select};
            default:       rd_val = 8'h00;
        endcase
    end

    // Address phase capture and read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr   <= 1'b0;
            ap_addr <= 8'h00;
            hrdata  <= 32'h0;
        end else if (ce) begin
            ap_wr   <= addr_valid && hwrite;
            ap_addr <= haddr;
            if (rd_now) begin
                hrdata <= {24'h0, rd_val};
            end
        end
    end

    // ----------------------------------------
    // Software registers and soft reset
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cr1              <= `TBI_CR1_RST;
            oar              <= `TBI_OAR_RST;
            low_power_idle_mode_run_select <= 1'b0;
            mode             <= `TBI_MODE_PORT;
            swr_armed        <= 1'b0;
            srst             <= 1'b0;
        end else if (ce) begin
            srst     <= 1'b0;
            cr1.done <= !srst;
            if (srst) begin
                cr1.bcs          <= 3'h0;
                cr1.ack          <= 1'b0;
                cr1.rate         <= 3'h0;
                oar              <= `TBI_OAR_RST;
                low_power_idle_mode_run_select <= 1'b0;
                mode             <= `TBI_MODE_PORT;
                swr_armed        <= 1'b0;
            end else begin
                if (wr_now && ap_addr == `TBI_CR1_OFS) begin
                    cr1.bcs  <= hwdata[7:5];
                    cr1.ack  <= hwdata[4];
                    cr1.rate <= hwdata[2:0];
                end
                if (wr_now && ap_addr == `TBI_OAR_OFS) begin
                    oar <= hwdata[7:0];
                end
                if (wr_now && ap_addr == `TBI_IDLE_OFS) begin
                    low_power_idle_mode_run_select <= hwdata[0];
                end
                if (cr2_wr) begin
                    mode <= hwdata[`TBI_CR2_MODE_HI:`TBI_CR2_MODE_LO];
                    if (hwdata[`TBI_CR2_SWR_HI:`TBI_CR2_SWR_LO] == `TBI_SWR_FIRST) begin
                        swr_armed <= 1'b1;
                    end else if (hwdata[`TBI_CR2_SWR_HI:`TBI_CR2_SWR_LO] == `TBI_SWR_SECOND) begin
                        swr_armed <= 1'b0;
                        srst      <= swr_armed;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Word framing
    // ----------------------------------------
    assign last_bit   = (first_word || cr1.ack) ? `TBI_WORD_ACK : `TBI_WORD_BITS;
    assign word_end   = scl_fall && (bitn == last_bit);
    assign irq_evt    = word_end && (st.master_select || st.aas || st.al || (first_word && oar[0]));
    // Last data bit holds until its fall is seen, so the line never moves while clock is high
    assign drive_data = st.trx && !start_hold && (st.master_select || (st.aas && !first_word)) &&
                        ((bitn < `TBI_WORD_BITS) ||
                         (bitn == `TBI_WORD_BITS && scl_s2 && scl_d));
    // Acknowledge starts after the eighth fall and stands through the ninth clock
    assign ack_low    = ((bitn == `TBI_WORD_BITS && !(scl_s2 && scl_d)) ||
                         bitn == `TBI_WORD_ACK) &&
                        ((st.master_select && !st.trx && !first_word && cr1.ack) ||
                         (!st.master_select && st.aas && (first_word || (!st.trx && cr1.ack))));
    assign al_evt     = scl_rise && st.master_select && drive_data && shreg[7] && !sda_s2;
    assign go         = cr2_wr && (hwdata[7:4] == 4'hf) && !st.bb &&
                        (hwdata[`TBI_CR2_MODE_HI:`TBI_CR2_MODE_LO] == `TBI_MODE_I2C);

    // Bit counter and shift register, shifted at falls so data only moves while clock is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shreg      <= 8'h00;
            bitn       <= 4'h0;
            first_word <= 1'b0;
        end else if (ce) begin
            if (srst) begin
                shreg      <= 8'h00;
                bitn       <= 4'h0;
                first_word <= 1'b0;
            end else if (start_det) begin
                bitn       <= 4'h0;
                first_word <= 1'b1;
            end else begin
                if (scl_rise && bitn < `TBI_WORD_ACK) begin
                    bitn <= bitn + 4'h1;
                end
                if (scl_fall && bitn != 4'h0 && bitn <= `TBI_WORD_BITS) begin
                    shreg <= {shreg[6:0], st.last_received_bit};
                end
                if (word_end) begin
                    bitn       <= 4'h0;
                    first_word <= 1'b0;
                end
                if (wr_now && ap_addr == `TBI_DBUF_OFS) begin
                    shreg <= hwdata[7:0];
                end
            end
        end
    end

    // ----------------------------------------
    // Status flags, clears first so events win
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '{pin: 1'b1, default: 1'b0};
        end else if (ce) begin
            if (srst) begin
                st <= '{pin: 1'b1, default: 1'b0};
            end else begin
                if (cr2_wr) begin
                    st.master_select <= hwdata[`TBI_CR2_MST];
                    st.trx <= hwdata[`TBI_CR2_TRX];
                    st.al  <= 1'b0;
                    if (hwdata[`TBI_CR2_PIN]) begin
                        st.pin <= 1'b1;
                    end
                end
                if (dbuf_acc) begin
                    st.al  <= 1'b0;
                    st.aas <= 1'b0;
                    st.pin <= 1'b1;
                end
                if (scl_rise) begin
                    st.last_received_bit <= sda_s2;
                end
                if (start_det) begin
                    st.bb  <= 1'b1;
                    st.ad0 <= 1'b0;
                end
                if (stop_det) begin
                    st.bb  <= 1'b0;
                    st.ad0 <= 1'b0;
                    st.master_select <= 1'b0;
                    st.trx <= 1'b0;
                end
                // Address byte complete on the eighth fall
                if (scl_fall && first_word && bitn == `TBI_WORD_BITS && !st.master_select) begin
                    if ({shreg[6:0], st.last_received_bit} == `TBI_GEN_CALL) begin
                        st.ad0 <= 1'b1;
                    end
                    if (!oar[0] && ({shreg[6:0], st.last_received_bit} == `TBI_GEN_CALL ||
                                    shreg[6:0] == oar[7:1])) begin
                        st.aas <= 1'b1;
                        st.trx <= st.last_received_bit;
                    end
                end
                if (word_end && first_word && oar[0] && !st.master_select) begin
                    st.aas <= 1'b1;
                end
                if (irq_evt) begin
                    st.pin <= 1'b0;
                end
                // Master address acknowledged: direction decides transmit
                if (word_end && first_word && st.master_select && !st.last_received_bit) begin
                    st.trx <= !shreg[0];
                end
                if (al_evt) begin
                    st.al  <= 1'b1;
                    st.master_select <= 1'b0;
                    st.trx <= 1'b0;
                end
            end
        end
    end

    // Interrupt strobe to the system
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transfer_interrupt <= 1'b0;
        end else if (ce) begin
            transfer_interrupt <= irq_evt && !srst;
        end
    end

    // ----------------------------------------
    // Clock generator and clock stretching
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state      <= tbi_pkg::TBI_IDLE;
            cnt        <= 12'h0;
            start_hold <= 1'b0;
            slv_hold   <= 1'b0;
        end else if (run) begin
            if (srst || !i2c_en) begin
                state      <= tbi_pkg::TBI_IDLE;
                cnt        <= 12'h0;
                start_hold <= 1'b0;
                slv_hold   <= 1'b0;
            end else begin
                if (scl_fall) begin
                    start_hold <= 1'b0;
                end
                if (irq_evt && !st.master_select) begin
                    slv_hold <= 1'b1;
                end
                unique case (state)
                    tbi_pkg::TBI_IDLE: begin
                        if (go) begin
                            state      <= tbi_pkg::TBI_START;
                            start_hold <= 1'b1;
                            cnt        <= 12'h0;
                        end else if (slv_hold && st.pin) begin
                            cnt <= cnt + 12'h1;
                            if (cnt >= t_low) begin
                                slv_hold <= 1'b0;
                                cnt      <= 12'h0;
                            end
                        end else begin
                            cnt <= 12'h0;
                        end
                    end
                    tbi_pkg::TBI_START: begin
                        cnt <= cnt + 12'h1;
                        if (cnt >= t_high) begin
                            state <= tbi_pkg::TBI_LOW;
                            cnt   <= 12'h0;
                        end
                    end
                    tbi_pkg::TBI_LOW: begin
                        if (!st.pin) begin
                            cnt <= 12'h0;
                        end else if (cnt >= t_low) begin
                            state <= tbi_pkg::TBI_HIGH;
                            cnt   <= 12'h0;
                        end else begin
                            cnt <= cnt + 12'h1;
                        end
                    end
                    tbi_pkg::TBI_HIGH: begin
                        if (scl_fall) begin
                            state <= tbi_pkg::TBI_LOW;
                            cnt   <= 12'h0;
                        end else if (scl_s2) begin
                            cnt <= cnt + 12'h1;
                            if (cnt >= t_high) begin
                                state <= tbi_pkg::TBI_LOW;
                                cnt   <= 12'h0;
                            end
                        end
                    end
                    default: begin
                        state <= tbi_pkg::TBI_IDLE;
                        cnt   <= 12'h0;
                    end
                endcase
                if (!st.master_select && state != tbi_pkg::TBI_IDLE) begin
                    state <= tbi_pkg::TBI_IDLE;
                    cnt   <= 12'h0;
                end
            end
        end
    end

    // Open-drain drives: enable pulls the line low
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = i2c_en && ((state == tbi_pkg::TBI_LOW) || slv_hold);
    assign sda_oe = i2c_en && (start_hold || ack_low ||
                    (drive_data && !shreg[7]));

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_al_on_mismatch: assert property (@(posedge hclk) disable iff (!hresetn)
        al_evt && !srst |=> st.al) else $error("lost arbitration not flagged");

    chk_al_drops_master: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st.al) |-> !st.master_select && !st.trx ##1 state == tbi_pkg::TBI_IDLE)
        else $error("master kept after lost arbitration");

    chk_dbuf_clears: assert property (@(posedge hclk) disable iff (!hresetn)
        dbuf_acc && !scl_fall && !scl_rise |=> !st.aas && !st.al && st.pin)
        else $error("buffer access did not clear flags");

    chk_gc_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        (start_det || stop_det) && !srst |=> !st.ad0 && (st.bb == $past(start_det)))
        else $error("general call or busy wrong after condition");

    chk_lrb_sample: assert property (@(posedge hclk) disable iff (!hresetn)
        scl_rise && !srst |=> st.last_received_bit == $past(sda_s2))
        else $error("last bit not latched");

    chk_soft_reset: assert property (@(posedge hclk) disable iff (!hresetn)
        srst && ce |=> mode == `TBI_MODE_PORT && !cr1.done && st.pin ##1 !ce || cr1.done)
        else $error("soft reset sequence wrong");

    chk_pin_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_evt && !srst && st.master_select |=> !st.pin && transfer_interrupt && scl_oe)
        else $error("word end did not stall clock");

    chk_start_gen: assert property (@(posedge hclk) disable iff (!hresetn)
        go && run && state == tbi_pkg::TBI_IDLE |=> state == tbi_pkg::TBI_START && sda_oe && !scl_oe)
        else $error("start condition not issued");

endmodule

// >>> tb/tbi_partner.sv
// Far-side slave receiver that acknowledges every address byte
`timescale 1ns/100ps
module tbi_partner (
    // Bus wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Acknowledge drive and captured byte
    output logic            sda_oe,
    output logic [7:0]      rx_byte
);
    int cnt = 9;
    initial sda_oe = 1'b0;
    // Start condition restarts the bit count
    always @(negedge sda) if (scl) cnt = 0;
    // Shift data in at the first eight clock rises after a start, MSB first
    always @(posedge scl) if (cnt < 8) begin
        rx_byte = {rx_byte[6:0], sda};
        cnt++;
    end
    // Pull data low for the ninth clock only
    always @(negedge scl) begin
        if (cnt == 8 && !sda_oe) sda_oe = 1'b1;
        else if (sda_oe) begin
            sda_oe = 1'b0;
            cnt = 9;
        end
    end
endmodule

// >>> tb/tbi_top_tb.sv
// Self-checking bench for the two-wire bus block
`timescale 1ns/100ps
module tbi_top_tb;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata, q;
    logic        hreadyout, hresp, tint, scl_o, scl_oe, sda_o, sda_oe, p_oe;
    logic        jam = 1'b0, lpi = 1'b0;
    logic [7:0]  rx, ab;
    wire         scl = ~scl_oe;
    wire         sda = ~(sda_oe | p_oe | jam);
    int          num_errors = 0, num_checks = 0, k;
    integer      seed = 32'h4356a4e9;
    always #2 hclk = ~hclk;
    tbi_top i_tbi_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_power_idle_mode(lpi),
        .transfer_interrupt(tint), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
    tbi_partner i_tbi_partner (.scl(scl), .sda(sda), .sda_oe(p_oe), .rx_byte(rx));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite transfer, waiting on hready in both phases
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    // Status after the address word: master, busy, no pin, ack seen, trx by direction
    function automatic logic [7:0] exp_sr(input logic dir);
        return dir ? 8'ha0 : 8'he0;
    endfunction
    // Low period in system clocks for a rate code
    function automatic int t_low_exp(input int rate);
        return 2 * ((1 << (rate + 3)) + 29);
    endfunction
    task automatic final_report;
        if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        num_errors++;
        final_report;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, 8'h00, 0); chk(q, 32'h08);
        for (int i = 0; i < 2; i++) begin
            ab = 8'({$random(seed)} % 128 * 2 + i);
            bus(1, 8'h14, 8'h01);
            lpi <= 1'b1;
            bus(0, 8'h14, 0); chk(q, 32'h1);
            bus(1, 8'h10, 8'h02);
            bus(1, 8'h04, 8'h18);
            bus(0, 8'h08, 0); chk(q, 32'h10);
            bus(1, 8'h00, 8'h10);
            bus(1, 8'h0c, ab);
            bus(1, 8'h04, 8'hf8);
            for (k = 0; k < 4000 && tint !== 1'b1; k++) @(negedge hclk);
            chk(k < 4000, 1);
            @(posedge hclk);
            chk(rx, ab);
            bus(0, 8'h08, 0); chk(q, exp_sr(ab[0]));
            bus(0, 8'h0c, 0);
            bus(0, 8'h08, 0); chk(q[4], 1'b1);
            for (k = 0; k < 400 && scl !== 1'b1; k++) @(posedge hclk);
            chk(k >= t_low_exp(0) - 8 && k <= t_low_exp(0) + 4, 1);
            lpi <= 1'b0;
            bus(1, 8'h04, 8'h1a);
            bus(1, 8'h04, 8'h19);
            repeat (4) @(posedge hclk);
            bus(0, 8'h00, 0); chk(q, 32'h08);
            bus(0, 8'h08, 0); chk(q, 32'h10);
            bus(0, 8'h14, 0); chk(q, 32'h0);
        end
        // Another master holds the data line low while a one is sent
        bus(1, 8'h04, 8'h18);
        bus(1, 8'h0c, ab | 8'h80);
        bus(1, 8'h04, 8'hf8);
        repeat (8) @(posedge hclk);
        jam <= 1'b1;
        repeat (300) @(posedge hclk);
        jam <= 1'b0;
        repeat (8) @(posedge hclk);
        bus(0, 8'h08, 0); chk(q, 32'h18);
        bus(0, 8'h0c, 0);
        bus(0, 8'h08, 0); chk(q, 32'h10);
        // Bus seen free above, so port mode may be chosen; no start without bus mode
        bus(1, 8'h04, 8'h10);
        bus(1, 8'h04, 8'hf0);
        repeat (200) @(posedge hclk);
        bus(0, 8'h08, 0); chk(q, 32'hd0);
        chk({scl, sda}, 2'b11);
        final_report;
    end
endmodule
